// >>> tpgr_regs.sv
`timescale 1ns/1ps
module tpgr_regs (
   input  wire logic                      clk,
   input  wire logic                      arst_n,
   input  wire logic                      ce,
   input  wire logic                      req_valid,
   input  wire tpgr_pkg::tpgr_req_t       req,
   input  wire tpgr_pkg::tpgr_meas_t      meas,
   input  wire logic [31:0]               service_key_ref,
   input  wire logic [31:0]               factory_key_ref,
   input  wire logic                      logout,
   input  wire logic                      nv_logging_on,
   input  wire logic [9:0]                nv_logging_interval,
   output logic                           ack,
   output logic                           refused,
   output logic [15:0]                    rdata,
   output tpgr_pkg::tpgr_level_t          session_level,
   output logic                           commit_pulse,
   output logic                           device_reset_pulse,
   output logic                           failure_clear_pulse,
   output logic [31:0]                    user_key,
   output logic [3:0]                     loop_poll_id,
   output logic                           loop_forced_4ma,
   output logic [3:0]                     loop_preamble_count,
   output tpgr_pkg::tpgr_time_t           time_sync_policy,
   output logic [31:0]                    stats_cycle_base,
   output logic                           logging_on,
   output logic [9:0]                     logging_interval,
   output logic [31:0]                    supplied_pressure_value,
   output logic [31:0]                    supplied_temperature_value
);
   import tpgr_pkg::*;

   logic [15:0] wr_high;
   logic [15:0] rd_low;
   logic        restored;
   logic [31:0] pressure_filtered;
   logic [31:0] outside_temperature;
   logic [31:0] factor_now;
   logic [31:0] raw_snap;
   logic [31:0] mean_snap;
   logic [31:0] instant_snap;
   logic [31:0] wword;
   logic [15:0] base;
   logic        odd;
   logic        do_write;
   logic        bad_value;
   logic        known;
   logic [31:0] rword;

   function automatic logic is_hex(input logic [7:0] c);
      is_hex = (c >= 8'h30 && c <= 8'h39) || (c >= 8'h41 && c <= 8'h46) || (c >= 8'h61 && c <= 8'h66);
   endfunction : is_hex

   function automatic logic [7:0] fold(input logic [7:0] c);
      fold = (c >= 8'h61 && c <= 8'h66) ? (c - 8'h20) : c;
   endfunction : fold

   // Case-insensitive match of a four-character hex key
   function automatic logic key_match(input logic [31:0] w, input logic [31:0] ref_key);
      key_match = 1'b1;
      for (int i = 0; i < 4; i++) begin
         if (!is_hex(w[8*i +: 8]) || fold(w[8*i +: 8]) != fold(ref_key[8*i +: 8])) begin
            key_match = 1'b0;
         end
      end
   endfunction : key_match

   function automatic logic in_range(input logic [31:0] v, input logic [31:0] lo, input logic [31:0] hi);
      in_range = (v >= lo) && (v <= hi);
   endfunction : in_range

   // Even address carries the high half; the odd address completes the word
   always_comb begin
      base     = {req.addr[15:1], 1'b0};
      odd      = req.addr[0];
      wword    = {wr_high, req.data};
      do_write = req_valid && req.write && odd;
      known    = 1'b1;
      unique case (base)
         A_RAW, A_MEAN, A_INSTANT, A_FILT, A_FACTOR, A_OTEMP,
         A_SVC_KEY, A_FAC_KEY, A_USER_KEY, A_COMMIT, A_RESET, A_FCLEAR,
         A_POLL, A_LOOP, A_PREAMBLE, A_TIME, A_STATS, A_LOGCTL,
         A_LOGINT, A_SUP_PRS, A_SUP_TEMP: known = 1'b1;
         default: known = 1'b0;
      endcase
      bad_value = 1'b0;
      unique case (base)
         A_POLL:     bad_value = !in_range(wword, 32'h0, POLL_MAX);
         A_LOOP:     bad_value = !in_range(wword, 32'h0, LOOP_MAX);
         A_PREAMBLE: bad_value = !in_range(wword, PRE_MIN, PRE_MAX);
         A_TIME:     bad_value = !in_range(wword, 32'h0, TIME_MAX);
         A_LOGCTL:   bad_value = !in_range(wword, 32'h0, LOOP_MAX);
         A_LOGINT:   bad_value = !in_range(wword, INT_MIN, INT_MAX);
         A_USER_KEY: bad_value = (session_level == TPGR_USER);
         A_RAW, A_MEAN, A_INSTANT, A_FILT, A_FACTOR, A_OTEMP: bad_value = 1'b1;
         default:    bad_value = 1'b0;
      endcase
   end

   always_comb begin
      rword = 32'h0;
      unique case (base)
         A_RAW:      rword = raw_snap;
         A_MEAN:     rword = mean_snap;
         A_INSTANT:  rword = instant_snap;
         A_FILT:     rword = pressure_filtered;
         A_FACTOR:   rword = factor_now;
         A_OTEMP:    rword = outside_temperature;
         A_SVC_KEY:  rword = (session_level == TPGR_USER) ? 32'h0 : service_key_ref;
         A_FAC_KEY:  rword = (session_level == TPGR_USER) ? 32'h0 : factory_key_ref;
         A_USER_KEY: rword = user_key;
         A_POLL:     rword = {28'h0, loop_poll_id};
         A_LOOP:     rword = {31'h0, !loop_forced_4ma};
         A_PREAMBLE: rword = {28'h0, loop_preamble_count};
         A_TIME:     rword = {30'h0, time_sync_policy};
         A_STATS:    rword = stats_cycle_base;
         A_LOGCTL:   rword = {31'h0, logging_on};
         A_LOGINT:   rword = {22'h0, logging_interval};
         A_SUP_PRS:  rword = supplied_pressure_value;
         A_SUP_TEMP: rword = supplied_temperature_value;
         default:    rword = 32'h0;
      endcase
   end

   // Bus handshake: answer one cycle after each request
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ack     <= 1'b0;
         refused <= 1'b0;
         rdata   <= 16'h0;
         wr_high <= 16'h0;
         rd_low  <= 16'h0;
      end else if (ce) begin
         ack     <= req_valid;
         refused <= req_valid && (!known || (req.write && odd && bad_value));
         if (req_valid && !req.write) begin
            if (!odd) begin
               rdata  <= rword[31:16];
               rd_low <= rword[15:0];
            end else begin
               rdata <= rd_low;
            end
         end
         if (req_valid && req.write && !odd) begin
            wr_high <= req.data;
         end
      end
   end

   // Measured values are sampled so a read sees one consistent word
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         raw_snap     <= 32'h0;
         mean_snap    <= 32'h0;
         instant_snap <= 32'h0;
         factor_now   <= FLOAT_ONE;
      end else if (ce) begin
         raw_snap     <= meas.raw_counts;
         mean_snap    <= meas.mean_counts;
         instant_snap <= meas.pressure_now;
         factor_now   <= meas.factor_on ? meas.factor : FLOAT_ONE;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pressure_filtered <= 32'h0;
      end else if (ce) begin
         unique case (meas.calc_mode)
            4'h1, 4'h4, 4'h5: pressure_filtered <= supplied_pressure_value;
            default:          pressure_filtered <= meas.pressure_calc;
         endcase
      end
   end

   // Other modes keep the last temperature rather than show stale junk
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         outside_temperature <= 32'h0;
      end else if (ce) begin
         unique case (meas.calc_mode)
            4'h1, 4'h2, 4'h3: outside_temperature <= meas.tube_temp;
            4'h6, 4'h7:       outside_temperature <= supplied_temperature_value;
            default:          outside_temperature <= outside_temperature;
         endcase
      end
   end

   // Writing the service or factory key register is a login attempt
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         session_level <= TPGR_USER;
      end else if (ce) begin
         if (logout) begin
            session_level <= TPGR_USER;
         end else if (do_write && base == A_FAC_KEY && key_match(wword, factory_key_ref)) begin
            session_level <= TPGR_FACTORY;
         end else if (do_write && base == A_SVC_KEY && key_match(wword, service_key_ref)) begin
            session_level <= TPGR_SERVICE;
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         user_key <= USER_KEY_RST;
      end else if (ce && do_write && base == A_USER_KEY && !bad_value) begin
         user_key <= wword;
      end
   end

   // Command registers only pulse; they read back as zero
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         commit_pulse        <= 1'b0;
         device_reset_pulse  <= 1'b0;
         failure_clear_pulse <= 1'b0;
      end else if (ce) begin
         commit_pulse        <= do_write && base == A_COMMIT && wword == CMD_ONE;
         device_reset_pulse  <= do_write && base == A_RESET && wword == CMD_ONE;
         failure_clear_pulse <= do_write && base == A_FCLEAR && wword == CMD_ONE;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         loop_poll_id        <= POLL_RST;
         loop_forced_4ma     <= 1'b0;
         loop_preamble_count <= PRE_RST;
         time_sync_policy    <= TPGR_TIME_NONE;
         stats_cycle_base    <= STATS_RST;
      end else if (ce && do_write && !bad_value) begin
         unique case (base)
            A_POLL:     loop_poll_id        <= wword[3:0];
            A_LOOP:     loop_forced_4ma     <= !wword[0];
            A_PREAMBLE: loop_preamble_count <= wword[3:0];
            A_TIME:     time_sync_policy    <= tpgr_time_t'(wword[1:0]);
            A_STATS:    stats_cycle_base    <= wword;
            default:    loop_poll_id        <= loop_poll_id;
         endcase
      end
   end

   // Logging state is restored from non-volatile copies after every reset
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         restored         <= 1'b0;
         logging_on       <= 1'b0;
         logging_interval <= INT_RST;
      end else if (ce) begin
         if (!restored) begin
            restored         <= 1'b1;
            logging_on       <= nv_logging_on;
            logging_interval <= (nv_logging_interval == 10'h0) ? INT_RST : nv_logging_interval;
         end else if (do_write && !bad_value && base == A_LOGCTL) begin
            logging_on <= wword[0];
         end else if (do_write && !bad_value && base == A_LOGINT) begin
            logging_interval <= wword[9:0];
         end
      end
   end

   // Supplied values bypass the commit path and apply next cycle
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         supplied_pressure_value    <= 32'h0;
         supplied_temperature_value <= 32'h0;
      end else if (ce && do_write) begin
         if (base == A_SUP_PRS) begin
            supplied_pressure_value <= wword;
         end
         if (base == A_SUP_TEMP) begin
            supplied_temperature_value <= wword;
         end
      end
   end
endmodule : tpgr_regs

// >>> tpgr_pkg.sv
// Overview of operation
// - Raw pressure converter sample readable as 32-bit read-only input register.
// - Filtered pressure converter sample readable as separate 32-bit read-only register.
// - Calculation modes 1, 4, 5: filtered pressure mirrors supplied pressure value.
// - Correction factor register reads exactly 1.0 while correction is disabled.
// - Outside temperature: tube temperature in modes 1-3, supplied value in 6-7.
// - Service/factory keys are four hex characters, either case, hidden at user level.
// - User key is four ASCII characters, default four ASCII ones.
// - User key writes accepted only at service or factory access level.
// - Writing 1 to commit register stores modified setup in non-volatile memory.
// - Writing 1 to reset request register performs a full device reset.
// - Writing 1 to failure clear register clears non-volatile failure counters.
// - Loop poll id 0 to 15, default 0; nonzero does not disable loop.
// - Loop state 0 forces loop to 4mA; state 1 follows assigned parameters.
// - Preamble count 5 to 15, default 5, before each loop response.
// - Time policy: 0 forbids, 1 trusted servers only, 2 any server.
// - Statistic cycle register sets sensor cycles sampled per statistic.
// - Logging control 0 stops, 1 starts, at once, kept across resets.
// - Logging interval 1 to 600 seconds, default 1 second.
// - Newly written supplied pressure takes effect immediately, no commit needed.
package tpgr_pkg;
   localparam logic [15:0] A_RAW      = 16'h4600;
   localparam logic [15:0] A_MEAN     = 16'h4602;
   localparam logic [15:0] A_INSTANT  = 16'h4604;
   localparam logic [15:0] A_FILT     = 16'h4606;
   localparam logic [15:0] A_FACTOR   = 16'h4608;
   localparam logic [15:0] A_OTEMP    = 16'h460a;
   localparam logic [15:0] A_SVC_KEY  = 16'h6000;
   localparam logic [15:0] A_FAC_KEY  = 16'h6002;
   localparam logic [15:0] A_USER_KEY = 16'h6004;
   localparam logic [15:0] A_COMMIT   = 16'h6006;
   localparam logic [15:0] A_RESET    = 16'h6008;
   localparam logic [15:0] A_FCLEAR   = 16'h600a;
   localparam logic [15:0] A_POLL     = 16'h60a0;
   localparam logic [15:0] A_LOOP     = 16'h60a2;
   localparam logic [15:0] A_PREAMBLE = 16'h60a4;
   localparam logic [15:0] A_TIME     = 16'h60ae;
   localparam logic [15:0] A_STATS    = 16'h60d0;
   localparam logic [15:0] A_LOGCTL   = 16'h60d2;
   localparam logic [15:0] A_LOGINT   = 16'h60d4;
   localparam logic [15:0] A_SUP_PRS  = 16'h6620;
   localparam logic [15:0] A_SUP_TEMP = 16'h662a;

   localparam logic [31:0] USER_KEY_RST = 32'h31313131;
   localparam logic [31:0] FLOAT_ONE    = 32'h3f800000;
   localparam logic [31:0] CMD_ONE      = 32'h00000001;
   localparam logic [31:0] POLL_MAX     = 32'h0000000f;
   localparam logic [31:0] PRE_MIN      = 32'h00000005;
   localparam logic [31:0] PRE_MAX      = 32'h0000000f;
   localparam logic [31:0] TIME_MAX     = 32'h00000002;
   localparam logic [31:0] LOOP_MAX     = 32'h00000001;
   localparam logic [31:0] INT_MIN      = 32'h00000001;
   localparam logic [31:0] INT_MAX      = 32'h00000258;
   localparam logic [31:0] STATS_RST    = 32'h00000001;
   localparam logic [3:0]  POLL_RST     = 4'h0;
   localparam logic [3:0]  PRE_RST      = 4'h5;
   localparam logic [9:0]  INT_RST      = 10'h001;

   typedef enum logic [1:0] {TPGR_USER, TPGR_SERVICE, TPGR_FACTORY} tpgr_level_t;
   typedef enum logic [1:0] {TPGR_TIME_NONE, TPGR_TIME_TRUSTED, TPGR_TIME_ANY} tpgr_time_t;

   typedef struct packed {
      logic        write;
      logic [15:0] addr;
      logic [15:0] data;
   } tpgr_req_t;

   typedef struct packed {
      logic [31:0] raw_counts;
      logic [31:0] mean_counts;
      logic [31:0] pressure_now;
      logic [31:0] pressure_calc;
      logic [31:0] factor;
      logic        factor_on;
      logic [31:0] tube_temp;
      logic [3:0]  calc_mode;
   } tpgr_meas_t;
endpackage : tpgr_pkg

// >>> tpgr_regs_checker.sv
`timescale 1ns/1ps
module tpgr_regs_checker (
   input wire logic                  clk,
   input wire logic                  arst_n,
   input wire logic                  ce,
   input wire logic                  req_valid,
   input wire tpgr_pkg::tpgr_req_t   req,
   input wire tpgr_pkg::tpgr_meas_t  meas,
   input wire logic                  ack,
   input wire logic                  refused,
   input wire logic [15:0]           rdata,
   input wire tpgr_pkg::tpgr_level_t session_level,
   input wire logic                  commit_pulse,
   input wire logic                  device_reset_pulse,
   input wire logic                  failure_clear_pulse,
   input wire logic [31:0]           user_key
);
   import tpgr_pkg::*;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!arst_n);
   sequence s_take;
      ce && req_valid;
   endsequence
   // Zero high half, then low half carrying 1; the pulse stands with the answer
   sequence s_cmd_one(a);
      s_take ##0 $past(req_valid) && $past(req.write) && $past(req.addr) == a && $past(req.data) == 16'h0000
         ##0 req.write && req.addr == a + 16'h0001 && req.data == 16'h0001 ##1 ack && !refused;
   endsequence
   a_answer_next: assert property (s_take |=> ack) else $error("request not answered");
   // A low enable freezes the answer, so a held ack is no new answer
   a_answer_cause: assert property (ack |-> ($past(ce) ? $past(req_valid) : $past(ack)))
      else $error("answer without request");
   a_commit_one: assert property (s_cmd_one(A_COMMIT) |-> commit_pulse) else $error("commit missing");
   a_commit_cause: assert property (commit_pulse |-> ack && $past(req.addr) == A_COMMIT + 16'h0001)
      else $error("commit without write");
   a_reset_one: assert property (s_cmd_one(A_RESET) |-> device_reset_pulse) else $error("reset missing");
   a_clear_one: assert property (s_cmd_one(A_FCLEAR) |-> failure_clear_pulse) else $error("clear missing");
   a_ro_refused: assert property (s_take ##0 req.write && req.addr[15:8] == 8'h46 && req.addr[0]
      |=> ack && refused) else $error("input register write taken");
   // A key read must not leak even through the low-half snapshot
   a_keys_hidden: assert property (ack && !$past(req.write) && $past(req.addr[15:2]) == 14'h1800
      && $past(session_level) == TPGR_USER |-> rdata == 16'h0000) else $error("key readable at user level");
   a_factor_one: assert property (ack && !$past(req.write) && $past(req.addr) == A_FACTOR && $past(arst_n, 2)
      && !$past(meas.factor_on) && !$past(meas.factor_on, 2) |-> rdata == FLOAT_ONE[31:16])
      else $error("factor not one while disabled");
   a_user_key_guard: assert property ($changed(user_key) |-> $past(session_level) != TPGR_USER)
      else $error("user key changed at user level");
endmodule : tpgr_regs_checker

bind tpgr_regs tpgr_regs_checker i_tpgr_regs_checker (.clk(clk), .arst_n(arst_n), .ce(ce), .req_valid(req_valid),
   .req(req), .meas(meas), .ack(ack), .refused(refused), .rdata(rdata), .session_level(session_level),
   .commit_pulse(commit_pulse), .device_reset_pulse(device_reset_pulse), .failure_clear_pulse(failure_clear_pulse),
   .user_key(user_key));

// >>> tpgr_master.sv
`timescale 1ns/1ps
module tpgr_master (
   input  wire logic           clk,
   output logic                req_valid,
   output tpgr_pkg::tpgr_req_t req
);
   import tpgr_pkg::*;
   typedef struct packed {logic rd; logic chk; logic refd; logic [15:0] data;} tpgr_exp_t;
   tpgr_exp_t exp_q[$];
   initial begin
      req_valid = 1'b0;
      req       = '0;
   end
   // Valid stays up after a half so back-to-back halves never touch it twice in one step
   task automatic half(input logic wr, input logic [15:0] a, input logic [15:0] d, input tpgr_exp_t e);
      req_valid = 1'b1;
      req       = '{write: wr, addr: a, data: d};
      exp_q.push_back(e);
      @(posedge clk);
      #1;
   endtask : half
   // Released lines show the inverse so a stale value cannot pass for a held one
   task automatic idle;
      req_valid = 1'b0;
      req       = ~req;
      @(posedge clk);
      #1;
   endtask : idle
   task automatic wr32(input logic [15:0] a, input logic [31:0] d, input logic refd);
      half(1'b1, a, d[31:16], '{1'b0, 1'b0, 1'b0, 16'h0000});
      half(1'b1, a + 16'h0001, d[15:0], '{1'b0, 1'b1, refd, 16'h0000});
   endtask : wr32
   task automatic rd32(input logic [15:0] a, input logic [31:0] e);
      half(1'b0, a, 16'h0000, '{1'b1, 1'b1, 1'b0, e[31:16]});
      half(1'b0, a + 16'h0001, 16'h0000, '{1'b1, 1'b1, 1'b0, e[15:0]});
   endtask : rd32
endmodule : tpgr_master

// >>> test_tpgr_regs.sv
`timescale 1ns/1ps
module test_tpgr_regs;
   import tpgr_pkg::*;
   logic        clk, arst_n, ce, logout, nv_logging_on, req_valid, ack, refused, loop_forced_4ma, logging_on;
   logic [2:0]  pulse;
   logic [3:0]  loop_poll_id, loop_preamble_count;
   logic [9:0]  nv_logging_interval, logging_interval;
   logic [15:0] rdata;
   logic [31:0] service_key_ref, factory_key_ref, user_key, stats_cycle_base, sup_p, sup_t, sup_p_now, sup_t_now;
   logic [31:0] shadow[logic [15:0]];
   logic [31:0] t_v[20];
   tpgr_req_t   req;
   tpgr_meas_t  meas;
   tpgr_level_t session_level;
   tpgr_time_t  time_sync_policy;
   int          fails, n_compared, seed;
   int          n_pulse[3];
   localparam logic [15:0] T_C[3]  = '{A_COMMIT, A_RESET, A_FCLEAR};
   localparam logic [19:0] T_R     = 20'h628aa;
   localparam logic [15:0] T_A[20] = '{A_POLL, A_POLL, A_LOOP, A_LOOP, A_LOOP, A_PREAMBLE, A_PREAMBLE, A_PREAMBLE,
      A_PREAMBLE, A_TIME, A_TIME, A_TIME, A_TIME, A_LOGCTL, A_LOGCTL, A_LOGCTL, A_LOGINT, A_LOGINT, A_LOGINT, A_STATS};

   tpgr_regs i_tpgr_regs (.clk(clk), .arst_n(arst_n), .ce(ce), .req_valid(req_valid), .req(req), .meas(meas),
      .service_key_ref(service_key_ref), .factory_key_ref(factory_key_ref), .logout(logout),
      .nv_logging_on(nv_logging_on), .nv_logging_interval(nv_logging_interval), .ack(ack), .refused(refused),
      .rdata(rdata), .session_level(session_level), .commit_pulse(pulse[0]), .device_reset_pulse(pulse[1]),
      .failure_clear_pulse(pulse[2]), .user_key(user_key), .loop_poll_id(loop_poll_id),
      .loop_forced_4ma(loop_forced_4ma), .loop_preamble_count(loop_preamble_count),
      .time_sync_policy(time_sync_policy), .stats_cycle_base(stats_cycle_base), .logging_on(logging_on),
      .logging_interval(logging_interval), .supplied_pressure_value(sup_p_now),
      .supplied_temperature_value(sup_t_now));
   tpgr_master i_tpgr_master (.clk(clk), .req_valid(req_valid), .req(req));

   task automatic check(input logic [31:0] got, input logic [31:0] want, input string what);
      n_compared++;
      if (got !== want) begin
         fails++;
         $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, got, want);
      end
   endtask : check
   function automatic logic [31:0] cfg_now(input logic [15:0] a);
      case (a)
         A_POLL:     return {28'h0, loop_poll_id};
         A_LOOP:     return {31'h0, ~loop_forced_4ma};
         A_PREAMBLE: return {28'h0, loop_preamble_count};
         A_TIME:     return {30'h0, time_sync_policy};
         A_STATS:    return stats_cycle_base;
         A_LOGCTL:   return {31'h0, logging_on};
         default:    return {22'h0, logging_interval};
      endcase
   endfunction : cfg_now
   task automatic give_verdict;
      $display("compared %0d, failed %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : give_verdict

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   initial begin
      repeat (20000) @(posedge clk);
      check(32'h1, 32'h0, "timeout");
      give_verdict();
   end
   // Answers are matched in request order against the notes the master left
   always @(posedge clk) begin
      for (int k = 0; k < 3; k++) begin
         if (pulse[k] === 1'b1)
            n_pulse[k]++;
      end
      if (ack === 1'b1 && i_tpgr_master.exp_q.size() == 0) begin
         check(32'h1, 32'h0, "answer without request");
      end else if (ack === 1'b1) begin
         if (i_tpgr_master.exp_q[0].chk)
            check({31'h0, refused}, {31'h0, i_tpgr_master.exp_q[0].refd}, "refused");
         if (i_tpgr_master.exp_q[0].rd)
            check({16'h0, rdata}, {16'h0, i_tpgr_master.exp_q[0].data}, "read data");
         i_tpgr_master.exp_q.delete(0);
      end
   end

   initial begin
      seed = 66;
      arst_n = 1'b0;
      ce = 1'b1;
      logout = 1'b0;
      nv_logging_on = 1'b1;
      nv_logging_interval = 10'h000;
      service_key_ref = 32'h31413242;
      factory_key_ref = 32'h43443945;
      meas = '0;
      t_v = '{32'hf, 32'h10, 32'h0, 32'h2, 32'h1, 32'h4, 32'hf, 32'h10, 32'h5, 32'h1, 32'h2, 32'h3, 32'h0, 32'h2,
         32'h0, 32'h1, 32'h258, 32'h259, 32'h0, 32'h0};
      shadow = '{A_POLL: 32'h0, A_LOOP: 32'h1, A_PREAMBLE: 32'h5, A_TIME: 32'h0, A_STATS: 32'h1, A_LOGCTL: 32'h1,
         A_LOGINT: 32'h1};
      repeat (4) @(posedge clk);
      #1;
      arst_n = 1'b1;
      i_tpgr_master.idle();
      foreach (shadow[a]) check(cfg_now(a), shadow[a], "reset value");
      check(user_key, USER_KEY_RST, "user key default");
      $display("test reset done");
      for (int m = 1; m < 8; m++) begin
         meas = {$random(seed), $random(seed), $random(seed), $random(seed), $random(seed), m[0], $random(seed), m[3:0]};
         sup_p = $random(seed);
         sup_t = $random(seed);
         i_tpgr_master.wr32(A_SUP_PRS, sup_p, 1'b0);
         i_tpgr_master.wr32(A_SUP_TEMP, sup_t, 1'b0);
         i_tpgr_master.idle();
         i_tpgr_master.rd32(A_FILT, (m == 1 || m == 4 || m == 5) ? sup_p : meas.pressure_calc);
         i_tpgr_master.rd32(A_RAW, meas.raw_counts);
         i_tpgr_master.rd32(A_MEAN, meas.mean_counts);
         i_tpgr_master.rd32(A_FACTOR, m[0] ? meas.factor : FLOAT_ONE);
         if (m < 4 || m > 5)
            i_tpgr_master.rd32(A_OTEMP, (m < 4) ? meas.tube_temp : sup_t);
         check(sup_p_now, sup_p, "supplied pressure");
         check(sup_t_now, sup_t, "supplied temperature");
      end
      i_tpgr_master.wr32(A_RAW, 32'h0, 1'b1);
      i_tpgr_master.half(1'b0, 16'h5000, 16'h0000, '{1'b0, 1'b1, 1'b1, 16'h0000});
      i_tpgr_master.idle();
      $display("test measurements done");
      i_tpgr_master.rd32(A_SVC_KEY, 32'h0);
      i_tpgr_master.rd32(A_FAC_KEY, 32'h0);
      i_tpgr_master.wr32(A_USER_KEY, 32'h32323232, 1'b1);
      i_tpgr_master.wr32(A_SVC_KEY, 32'h31613262, 1'b0);
      i_tpgr_master.idle();
      check({30'h0, session_level}, {30'h0, TPGR_SERVICE}, "login");
      i_tpgr_master.wr32(A_USER_KEY, 32'h32323232, 1'b0);
      i_tpgr_master.rd32(A_USER_KEY, 32'h32323232);
      i_tpgr_master.idle();
      // With the enable low even a logout must not move the session
      ce = 1'b0;
      logout = 1'b1;
      i_tpgr_master.idle();
      check({30'h0, session_level}, {30'h0, TPGR_SERVICE}, "frozen by enable");
      ce = 1'b1;
      i_tpgr_master.idle();
      logout = 1'b0;
      i_tpgr_master.idle();
      check(user_key, 32'h32323232, "user key");
      check({30'h0, session_level}, {30'h0, TPGR_USER}, "logout");
      $display("test keys done");
      // Commit comes before the reset request, as a master should order them
      for (int k = 0; k < 3; k++) begin
         i_tpgr_master.wr32(T_C[k], 32'h2, 1'b0);
         i_tpgr_master.wr32(T_C[k], CMD_ONE, 1'b0);
      end
      i_tpgr_master.idle();
      i_tpgr_master.idle();
      for (int k = 0; k < 3; k++) check(n_pulse[k], 32'h1, "command pulses");
      $display("test commands done");
      t_v[19] = $random(seed);
      for (int i = 0; i < 20; i++) begin
         i_tpgr_master.wr32(T_A[i], t_v[i], T_R[i]);
         if (!T_R[i])
            shadow[T_A[i]] = t_v[i];
         i_tpgr_master.rd32(T_A[i], shadow[T_A[i]]);
         check(cfg_now(T_A[i]), shadow[T_A[i]], "config output");
      end
      i_tpgr_master.idle();
      i_tpgr_master.idle();
      $display("test config done");
      arst_n = 1'b0;
      repeat (4) @(posedge clk);
      #1;
      arst_n = 1'b1;
      i_tpgr_master.idle();
      check(user_key, USER_KEY_RST, "user key after reset");
      check({31'h0, logging_on}, {31'h0, nv_logging_on}, "logging kept");
      check({22'h0, logging_interval}, {22'h0, INT_RST}, "interval restored");
      check(i_tpgr_master.exp_q.size(), 32'h0, "unanswered requests");
      $display("test second reset done");
      give_verdict();
   end
endmodule : test_tpgr_regs
